/* File: inc/pmta_defines.vh */
/*
 * constants for the program memory table access block: register offsets,
 * field positions, reset values, mode and operation codes, timing counts.
 * assumes nothing; definitions only.
 */
`ifndef PMTA_DEFINES_VH
`define PMTA_DEFINES_VH

// ****************************************
// register offsets (4-bit register index)
// ****************************************
`define PMTA_OFS_PTR_LOW    4'h0
`define PMTA_OFS_PTR_HIGH   4'h1
`define PMTA_OFS_CONTROL    4'h2
`define PMTA_OFS_STATUS     4'h3
`define PMTA_OFS_RLATCH_LOW 4'h4
`define PMTA_OFS_RLATCH_HI  4'h5
`define PMTA_OFS_WLATCH_LOW 4'h6
`define PMTA_OFS_WLATCH_HI  4'h7

// ****************************************
// control fields and reset values
// ****************************************
`define PMTA_CTL_MODE_MSB   1
`define PMTA_CTL_MODE_LSB   0
`define PMTA_CTL_RESET      2'h2
`define PMTA_PTR_RESET      16'h0000

// ****************************************
// memory modes
// ****************************************
`define PMTA_MODE_MICROPROC 2'h0
`define PMTA_MODE_EXT_MCU   2'h1
`define PMTA_MODE_MCU       2'h2
`define PMTA_MODE_PROT_MCU  2'h3

// ****************************************
// table operations on the command port
// ****************************************
`define PMTA_OP_LATCH_LOAD  2'h0
`define PMTA_OP_WRITE_PROG  2'h1
`define PMTA_OP_LATCH_READ  2'h2
`define PMTA_OP_READ_FETCH  2'h3

// ****************************************
// timing
// ****************************************
`define PMTA_WRITE_CYCLES   2
`define PMTA_SYNC_STAGES    2

`endif

/* File: src/pmta_word_latch.v */
/*
 * one 16-bit table latch, loadable a byte at a time or as a whole word.
 * assumes load_byte and load_word are never high together.
 */
`timescale 1ns/1ps
`default_nettype none

module pmta_word_latch #(
	parameter WIDTH = 16
) (
	// clock and reset
	input  wire             mclk,
	input  wire             resetn,
	// byte load
	input  wire             load_byte,
	input  wire             load_hi,
	input  wire [WIDTH/2-1:0] byte_in,
	// word load
	input  wire             load_word,
	input  wire [WIDTH-1:0] word_in,
	// contents
	output wire [WIDTH-1:0] word_out
);

	reg [WIDTH-1:0] word_reg;

	assign word_out = word_reg;

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			word_reg <= {WIDTH{1'b0}};
		end else if (load_word) begin
			word_reg <= word_in;
		end else if (load_byte) begin
			if (load_hi) begin
				word_reg[WIDTH-1:WIDTH/2] <= byte_in;
			end else begin
				word_reg[WIDTH/2-1:0] <= byte_in;
			end
		end
	end

endmodule // pmta_word_latch

`default_nettype wire

/* File: src/pmta_core.v */
/*
 * program memory table access: moves words between the 8-bit data side and
 * the 16-bit program memory, internal or external.
 * assumes commands come from core logic on mclk, external read data on pins,
 * and an internal program memory answering one cycle after int_re.
 */
// The address-and-strobe port and the register offsets are this design's own decisions.
// Behaviour
// - external table write takes two cycles, data driven in the second
// - external write follows the same step order as an internal write
// - increment operand set: pointer plus one after the write
// - read-and-fetch returns high read latch byte, reloads latch, maybe increments
// - external accesses use separate read and write latches
// - gated-off interrupt during external write: write done, top flag cleared
// - write-and-program loads source byte into latch, writes whole latch
// - increment operand zero leaves pointer unchanged
// - external memory only in microprocessor or extended microcontroller mode
`timescale 1ns/1ps
`default_nettype none
`include "pmta_defines.vh"

module pmta_core #(
	parameter NUM_IRQ = 3
) (
	// clock and reset
	input  wire               mclk,
	input  wire               resetn,
	// register port
	input  wire [3:0]         reg_addr,
	input  wire [7:0]         reg_wdata,
	input  wire               reg_wr,
	input  wire               reg_rd,
	output reg  [7:0]         reg_rdata,
	// table instruction port
	input  wire               cmd_valid,
	input  wire [1:0]         cmd_op,
	input  wire               cmd_byte_hi,
	input  wire               cmd_inc,
	input  wire [7:0]         cmd_src,
	output reg                cmd_busy,
	output reg                res_valid,
	output reg  [7:0]         res_data,
	// interrupt interaction
	input  wire               global_vector_disable,
	input  wire [NUM_IRQ-1:0] irq_enable,
	input  wire [NUM_IRQ-1:0] irq_flag,
	output reg  [NUM_IRQ-1:0] irq_flag_clear,
	// external program memory bus
	output reg  [15:0]        ext_addr,
	output reg  [15:0]        ext_wdata,
	output reg                ext_we,
	output reg                ext_re,
	input  wire [15:0]        ext_rdata,
	// internal program memory
	output reg  [15:0]        int_addr,
	output reg  [15:0]        int_wdata,
	output reg                int_we,
	output reg                int_re,
	input  wire [15:0]        int_rdata
);

	// ****************************************
	// state
	// ****************************************
	localparam ST_IDLE  = 3'h0;
	localparam ST_WRITE = 3'h1;
	localparam ST_RD_A  = 3'h2;
	localparam ST_RD_B  = 3'h3;
	localparam ST_RD_C  = 3'h4;

	reg  [2:0]  state_reg;
	reg  [15:0] pointer_reg;
	reg  [1:0]  mode_reg;
	reg         inc_reg;
	reg         is_ext_reg;
	reg  [15:0] rsync1_reg;
	reg  [15:0] rsync2_reg;
	reg  [15:0] int_hold_reg;
	wire [15:0] rlatch_word;
	wire [15:0] wlatch_word;

	wire ext_mode = (mode_reg == `PMTA_MODE_MICROPROC) ||
			(mode_reg == `PMTA_MODE_EXT_MCU);
	wire take     = cmd_valid && (state_reg == ST_IDLE);
	wire do_load  = take && (cmd_op == `PMTA_OP_LATCH_LOAD);
	wire do_write = take && (cmd_op == `PMTA_OP_WRITE_PROG);
	wire do_lread = take && (cmd_op == `PMTA_OP_LATCH_READ);
	wire do_fetch = take && (cmd_op == `PMTA_OP_READ_FETCH);
	wire fetched  = (state_reg == ST_RD_C);
	wire [15:0] fetch_word = is_ext_reg ? rsync2_reg : int_hold_reg;

	// highest priority pending source is the lowest index
	reg [NUM_IRQ-1:0] irq_pick;
	integer i;
	always @* begin
		irq_pick = {NUM_IRQ{1'b0}};
		for (i = NUM_IRQ - 1; i >= 0; i = i - 1) begin
			if (irq_flag[i] && irq_enable[i]) begin
				irq_pick = {NUM_IRQ{1'b0}};
				irq_pick[i] = 1'b1;
			end
		end
	end

	// ****************************************
	// table latches
	// ****************************************
	// with external memory the two latches are kept apart; internally a read
	// reloads the write latch too and a byte load reaches both, so they act
	// as one latch
	pmta_word_latch #(.WIDTH(16)) u_write_latch (
		.mclk      (mclk),
		.resetn    (resetn),
		.load_byte (do_load || do_write),
		.load_hi   (cmd_byte_hi),
		.byte_in   (cmd_src),
		.load_word (fetched && !is_ext_reg),
		.word_in   (fetch_word),
		.word_out  (wlatch_word)
	);

	pmta_word_latch #(.WIDTH(16)) u_read_latch (
		.mclk      (mclk),
		.resetn    (resetn),
		.load_byte ((do_load || do_write) && !ext_mode),
		.load_hi   (cmd_byte_hi),
		.byte_in   (cmd_src),
		.load_word (fetched),
		.word_in   (fetch_word),
		.word_out  (rlatch_word)
	);

	// ****************************************
	// external read data synchroniser
	// ****************************************
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rsync1_reg   <= 16'h0000;
			rsync2_reg   <= 16'h0000;
			int_hold_reg <= 16'h0000;
		end else begin
			rsync1_reg   <= ext_rdata;
			rsync2_reg   <= rsync1_reg;
			int_hold_reg <= int_rdata;
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg      <= ST_IDLE;
			pointer_reg    <= `PMTA_PTR_RESET;
			mode_reg       <= `PMTA_CTL_RESET;
			inc_reg        <= 1'b0;
			is_ext_reg     <= 1'b0;
			cmd_busy       <= 1'b0;
			res_valid      <= 1'b0;
			res_data       <= 8'h00;
			irq_flag_clear <= {NUM_IRQ{1'b0}};
			ext_addr       <= 16'h0000;
			ext_wdata      <= 16'h0000;
			ext_we         <= 1'b0;
			ext_re         <= 1'b0;
			int_addr       <= 16'h0000;
			int_wdata      <= 16'h0000;
			int_we         <= 1'b0;
			int_re         <= 1'b0;
		end else begin
			res_valid      <= 1'b0;
			irq_flag_clear <= {NUM_IRQ{1'b0}};
			ext_we         <= 1'b0;
			ext_re         <= 1'b0;
			int_we         <= 1'b0;
			int_re         <= 1'b0;
			// pointer and mode writes are ignored while an access is running
			if (reg_wr && state_reg == ST_IDLE && !take) begin
				if (reg_addr == `PMTA_OFS_PTR_LOW) begin
					pointer_reg[7:0] <= reg_wdata;
				end else if (reg_addr == `PMTA_OFS_PTR_HIGH) begin
					pointer_reg[15:8] <= reg_wdata;
				end else if (reg_addr == `PMTA_OFS_CONTROL) begin
					mode_reg <= reg_wdata[`PMTA_CTL_MODE_MSB:`PMTA_CTL_MODE_LSB];
				end
			end
			case (state_reg)
			ST_IDLE: begin
				inc_reg    <= cmd_inc;
				is_ext_reg <= ext_mode;
				if (do_write) begin
					// whole latch, with the new byte merged in, goes out next cycle
					ext_addr  <= pointer_reg;
					int_addr  <= pointer_reg;
					ext_wdata <= cmd_byte_hi ? {cmd_src, wlatch_word[7:0]} :
							{wlatch_word[15:8], cmd_src};
					int_wdata <= cmd_byte_hi ? {cmd_src, wlatch_word[7:0]} :
							{wlatch_word[15:8], cmd_src};
					ext_we    <= ext_mode;
					int_we    <= !ext_mode;
					cmd_busy  <= 1'b1;
					state_reg <= ST_WRITE;
					if (ext_mode && global_vector_disable) begin
						irq_flag_clear <= irq_pick;
					end
				end else if (do_fetch) begin
					res_data  <= rlatch_word[15:8];
					res_valid <= 1'b1;
					ext_addr  <= pointer_reg;
					int_addr  <= pointer_reg;
					ext_re    <= ext_mode;
					int_re    <= !ext_mode;
					cmd_busy  <= 1'b1;
					state_reg <= ST_RD_A;
				end else if (do_lread) begin
					res_data  <= cmd_byte_hi ? rlatch_word[15:8] : rlatch_word[7:0];
					res_valid <= 1'b1;
				end
			end
			ST_WRITE: begin
				if (inc_reg) begin
					pointer_reg <= pointer_reg + 16'h0001;
				end
				cmd_busy  <= 1'b0;
				state_reg <= ST_IDLE;
			end
			ST_RD_A: begin
				state_reg <= ST_RD_B;
			end
			ST_RD_B: begin
				state_reg <= ST_RD_C;
			end
			ST_RD_C: begin
				if (inc_reg) begin
					pointer_reg <= pointer_reg + 16'h0001;
				end
				cmd_busy  <= 1'b0;
				state_reg <= ST_IDLE;
			end
			default: begin
				cmd_busy  <= 1'b0;
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	// ****************************************
	// register read port
	// ****************************************
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `PMTA_OFS_PTR_LOW) begin
				reg_rdata <= pointer_reg[7:0];
			end else if (reg_addr == `PMTA_OFS_PTR_HIGH) begin
				reg_rdata <= pointer_reg[15:8];
			end else if (reg_addr == `PMTA_OFS_CONTROL) begin
				reg_rdata <= {6'h00, mode_reg};
			end else if (reg_addr == `PMTA_OFS_STATUS) begin
				reg_rdata <= {5'h00, state_reg != ST_IDLE, ext_mode, is_ext_reg};
			end else if (reg_addr == `PMTA_OFS_RLATCH_LOW) begin
				reg_rdata <= rlatch_word[7:0];
			end else if (reg_addr == `PMTA_OFS_RLATCH_HI) begin
				reg_rdata <= rlatch_word[15:8];
			end else if (reg_addr == `PMTA_OFS_WLATCH_LOW) begin
				reg_rdata <= wlatch_word[7:0];
			end else if (reg_addr == `PMTA_OFS_WLATCH_HI) begin
				reg_rdata <= wlatch_word[15:8];
			end else begin
				reg_rdata <= 8'h00;
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule // pmta_core

`default_nettype wire

/* File: tb/pmta_core_properties.sv */
/* timing checks on pmta_core: command answers, bus strobes, interrupt clears.
   assumes it is bound to every pmta_core instance. */
`timescale 1ns/1ps
`default_nettype none
module pmta_core_properties #(
	parameter NUM_IRQ = 3
) (
	// clock, reset, strobes
	input wire logic               mclk, resetn, reg_rd, cmd_valid, cmd_busy, res_valid,
	input wire logic               ext_we, ext_re, int_we, int_re, global_vector_disable,
	// buses
	input wire logic [1:0]         cmd_op,
	input wire logic [7:0]         reg_rdata,
	input wire logic [NUM_IRQ-1:0] irq_enable, irq_flag, irq_flag_clear
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	wire take = cmd_valid && !cmd_busy;
	wire [NUM_IRQ-1:0] pend = irq_enable & irq_flag;
	AST_WR_TWO: assert property (take && cmd_op == 2'h1 |=> cmd_busy && (ext_we || int_we) ##1 !cmd_busy)
		else $error("write not two cycles");
	AST_FETCH: assert property (take && cmd_op == 2'h3 |=> res_valid && (ext_re || int_re) && cmd_busy ##1 cmd_busy[*2] ##1 !cmd_busy)
		else $error("fetch sequence wrong");
	AST_LREAD: assert property (take && cmd_op == 2'h2 |=> res_valid && !cmd_busy)
		else $error("latch read answer wrong");
	AST_LOAD: assert property (take && cmd_op == 2'h0 |=> !res_valid && !ext_we && !int_we)
		else $error("latch load touched memory");
	AST_ONE_SIDE: assert property (!(ext_we && int_we) && !(ext_re && int_re))
		else $error("both memories strobed");
	AST_RDATA: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	AST_CLR_WR: assert property (irq_flag_clear != 0 |-> ext_we && $onehot(irq_flag_clear))
		else $error("flag clear outside external write");
	AST_CLR_PRIO: assert property (take && cmd_op == 2'h1 && global_vector_disable |=>
		irq_flag_clear == (ext_we ? ($past(pend) & (~$past(pend) + 1'b1)) : '0))
		else $error("wrong flag cleared");
	cover property (take && cmd_op == 2'h3);
	cover property (irq_flag_clear != 0);
	cover property (take && cmd_op == 2'h1 ##1 ext_we);
endmodule // pmta_core_properties
bind pmta_core pmta_core_properties #(.NUM_IRQ(NUM_IRQ)) pmta_core_properties_i (.mclk(mclk), .resetn(resetn),
	.reg_rd(reg_rd), .cmd_valid(cmd_valid), .cmd_busy(cmd_busy), .res_valid(res_valid), .ext_we(ext_we),
	.ext_re(ext_re), .int_we(int_we), .int_re(int_re), .global_vector_disable(global_vector_disable),
	.cmd_op(cmd_op), .reg_rdata(reg_rdata), .irq_enable(irq_enable), .irq_flag(irq_flag),
	.irq_flag_clear(irq_flag_clear));
`default_nettype wire

/* File: tb/pmta_ext_mem.sv */
/* model of the external program memory on the system bus.
   assumes strobes from pmta_core on mclk; read data given during ext_re. */
`timescale 1ns/1ps
`default_nettype none
module pmta_ext_mem (
	// bus
	input  wire logic        mclk,
	input  wire logic        ext_we,
	input  wire logic        ext_re,
	input  wire logic [15:0] ext_addr,
	input  wire logic [15:0] ext_wdata,
	output logic      [15:0] ext_rdata
);
	logic [15:0] mem [0:65535];
	logic [15:0] last = 16'h0000;
	always @(posedge mclk) begin
		if (ext_we) mem[ext_addr] <= ext_wdata;
		if (ext_re) last <= mem[ext_addr];
	end
	// released bus shows the inverse word so a stale value never matches
	assign ext_rdata = ext_re ? mem[ext_addr] : ~last;
endmodule // pmta_ext_mem
`default_nettype wire

/* File: tb/pmta_core_tb_top.sv */
/* bench for pmta_core: registers, table writes and reads, memory modes.
   assumes pmta_ext_mem on the bus and a one-cycle internal memory here. */
`timescale 1ns/1ps
`default_nettype none
`include "pmta_defines.vh"
module pmta_core_tb_top;
	logic mclk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, cmd_valid = 0, cmd_hi = 0, cmd_inc = 0, gvd = 0;
	logic [3:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, cmd_src = 0, reg_rdata, res_data, s_rd;
	logic [1:0] cmd_op = 0;
	logic [2:0] irq_enable = 0, irq_flag = 0, irq_flag_clear, s_clr;
	logic [15:0] ext_addr, ext_wdata, ext_rdata, int_addr, int_wdata, s_a, s_wd, int_rdata = 0;
	logic cmd_busy, res_valid, ext_we, ext_re, int_we, int_re, s_we, s_iwe, s_rv;
	logic [15:0] int_mem [0:255];
	int errors = 0, total_checks = 0, cyc = 0;
	pmta_core pmta_core_i (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_byte_hi(cmd_hi), .cmd_inc(cmd_inc), .cmd_src(cmd_src), .cmd_busy(cmd_busy), .res_valid(res_valid),
		.res_data(res_data), .global_vector_disable(gvd), .irq_enable(irq_enable), .irq_flag(irq_flag),
		.irq_flag_clear(irq_flag_clear), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_we(ext_we),
		.ext_re(ext_re), .ext_rdata(ext_rdata), .int_addr(int_addr), .int_wdata(int_wdata), .int_we(int_we),
		.int_re(int_re), .int_rdata(int_rdata));
	pmta_ext_mem pmta_ext_mem_i (.mclk(mclk), .ext_we(ext_we), .ext_re(ext_re), .ext_addr(ext_addr),
		.ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
	always @(posedge mclk) begin
		if (int_we) int_mem[int_addr[7:0]] <= int_wdata;
		int_rdata <= int_mem[int_addr[7:0]];
	end
	// ****************************************
	// bus and command tasks
	// ****************************************
	task automatic chk(input string n, input logic [15:0] e, g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge mclk); reg_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk); reg_addr <= a; reg_rd <= 1'b1;
		@(posedge mclk); reg_rd <= 1'b0;
		#1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
	endtask
	// snapshot of the cycle after the take; fetch is idle again three edges on
	task automatic cmd(input logic [1:0] op, input logic hi, inc, input logic [7:0] src);
		@(posedge mclk); cmd_valid <= 1'b1; cmd_op <= op; cmd_hi <= hi; cmd_inc <= inc; cmd_src <= src;
		@(posedge mclk); cmd_valid <= 1'b0;
		#1 {s_we, s_iwe, s_a, s_wd, s_clr, s_rv, s_rd} = {ext_we, int_we, ext_addr, ext_wdata, irq_flag_clear,
			res_valid, res_data};
		repeat (4) @(posedge mclk);
	endtask
	task automatic t_regs;
		rdc(`PMTA_OFS_PTR_LOW, 8'h00);
		rdc(`PMTA_OFS_CONTROL, {6'h00, `PMTA_CTL_RESET});
		rdc(4'hc, 8'h00);
		wr(`PMTA_OFS_RLATCH_HI, 8'h77);
		rdc(`PMTA_OFS_RLATCH_HI, 8'h00);
		$display("register test done");
	endtask
	task automatic t_ext_write;
		wr(`PMTA_OFS_CONTROL, {6'h00, `PMTA_MODE_EXT_MCU});
		wr(`PMTA_OFS_PTR_LOW, 8'h10);
		gvd <= 1'b1; irq_enable <= 3'b110; irq_flag <= 3'b110;
		cmd(`PMTA_OP_LATCH_LOAD, 1'b1, 1'b0, 8'hab);
		cmd(`PMTA_OP_WRITE_PROG, 1'b0, 1'b1, 8'hcd);
		chk("ext_we", 16'h1, {15'h0, s_we});
		chk("ext_addr", 16'h0010, s_a);
		chk("ext_wdata", 16'habcd, s_wd);
		chk("irq_flag_clear", 16'h2, {13'h0, s_clr});
		chk("ext_mem", 16'habcd, pmta_ext_mem_i.mem[16'h0010]);
		rdc(`PMTA_OFS_PTR_LOW, 8'h11);
		gvd <= 1'b0;
		cmd(`PMTA_OP_WRITE_PROG, 1'b1, 1'b0, 8'h5e);
		chk("ext_wdata", 16'h5ecd, s_wd);
		rdc(`PMTA_OFS_PTR_LOW, 8'h11);
		$display("external write test done");
	endtask
	task automatic t_ext_read;
		pmta_ext_mem_i.mem[16'h0020] = 16'h5a3c;
		pmta_ext_mem_i.mem[16'h0021] = 16'hc3a5;
		wr(`PMTA_OFS_PTR_LOW, 8'h20);
		cmd(`PMTA_OP_READ_FETCH, 1'b0, 1'b1, 8'h00);
		rdc(`PMTA_OFS_WLATCH_HI, 8'h5e);
		rdc(`PMTA_OFS_STATUS, 8'h03);
		cmd(`PMTA_OP_LATCH_READ, 1'b1, 1'b0, 8'h00);
		chk("res_data", 16'h15a, {7'h0, s_rv, s_rd});
		cmd(`PMTA_OP_LATCH_READ, 1'b0, 1'b0, 8'h00);
		chk("res_data", 16'h13c, {7'h0, s_rv, s_rd});
		cmd(`PMTA_OP_READ_FETCH, 1'b0, 1'b1, 8'h00);
		chk("res_data", 16'h15a, {7'h0, s_rv, s_rd});
		rdc(`PMTA_OFS_RLATCH_LOW, 8'ha5);
		rdc(`PMTA_OFS_PTR_LOW, 8'h22);
		$display("external read test done");
	endtask
	task automatic t_modes;
		for (int m = 0; m < 4; m++) begin
			wr(`PMTA_OFS_CONTROL, 8'(m));
			cmd(`PMTA_OP_WRITE_PROG, 1'b0, 1'b0, 8'h11);
			chk("ext_we", {15'h0, m < 2}, {15'h0, s_we});
			chk("int_we", {15'h0, m >= 2}, {15'h0, s_iwe});
		end
		chk("int_mem", 16'h5e11, int_mem[8'h22]);
		$display("memory mode test done");
	endtask
	// internal mode: one fetch fills both latches
	task automatic t_int_read;
		int_mem[8'h40] = 16'h9d62;
		wr(`PMTA_OFS_PTR_LOW, 8'h40);
		rdc(`PMTA_OFS_STATUS, 8'h00);
		cmd(`PMTA_OP_READ_FETCH, 1'b0, 1'b1, 8'h00);
		chk("res_data", 16'h1c3, {7'h0, s_rv, s_rd});
		rdc(`PMTA_OFS_RLATCH_HI, 8'h9d);
		rdc(`PMTA_OFS_WLATCH_LOW, 8'h62);
		rdc(`PMTA_OFS_PTR_LOW, 8'h41);
		$display("internal read test done");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			end_of_test;
		end
	end
	initial begin
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		t_regs;
		t_ext_write;
		t_ext_read;
		t_modes;
		t_int_read;
		end_of_test;
	end
endmodule // pmta_core_tb_top
`default_nettype wire
